// ===== pkg/adcdma_params.svh
/*
  constants for the converter dma address generator: field positions, codes, sizes.
  assumes inclusion by bare name from the package, interface and both end modules.
*/
`ifndef ADCDMA_PARAMS_SVH
`define ADCDMA_PARAMS_SVH

`define ADCDMA_CON1_ON_BIT      15
`define ADCDMA_CON1_MODE_BIT    12
`define ADCDMA_CON1_EXT_BIT     11
`define ADCDMA_CON1_SAMPLE_CONTROL_BIT    1
`define ADCDMA_CON2_REF_HI      15
`define ADCDMA_CON2_REF_LO      13
`define ADCDMA_CON2_SMPI_HI     6
`define ADCDMA_CON2_SMPI_LO     2
`define ADCDMA_CON3_DIV_HI      7
`define ADCDMA_CON3_DIV_LO      0
`define ADCDMA_CON4_LEN_HI      2
`define ADCDMA_CON4_LEN_LO      0
`define ADCDMA_IA_W             11
`define ADCDMA_CH_W             5
`define ADCDMA_LEN_W            3
`define ADCDMA_SMPI_W           5
`define ADCDMA_HALF_DEPTH       13
`define ADCDMA_EXT_CH_FIRST     27
`define ADCDMA_LEN_RESET        3'h0
`define ADCDMA_LEN_64           3'h6
`define ADCDMA_LEN_128          3'h7
`define ADCDMA_CH_LIMIT_64      16
`define ADCDMA_CH_LIMIT_128     8

`endif

// ===== pkg/adcdma_pkg.sv
/*
  types shared by both ends of the converter dma link.
  assumes adcdma_params.svh is on the include path.
*/
`include "adcdma_params.svh"

package adcdma_pkg;
  typedef logic [`ADCDMA_IA_W-1:0]   adcdma_addr_t;
  typedef logic [`ADCDMA_CH_W-1:0]   adcdma_chan_t;
  typedef logic [`ADCDMA_LEN_W-1:0]  adcdma_len_t;
  typedef logic [`ADCDMA_SMPI_W-1:0] adcdma_smpi_t;
  typedef enum logic {ADCDMA_MODE_INDIRECT, ADCDMA_MODE_EXTBUF} adcdma_mode_e;
  typedef enum {ADCDMA_IDLE, ADCDMA_REQ, ADCDMA_WAIT} adcdma_xfer_e;
endpackage : adcdma_pkg

// ===== pkg/adcdma_if.sv
/*
  link between the converter's dma side and the dma controller.
  assumes one clock shared by both ends; request held until acknowledged.
*/
`timescale 1ns/1ps
`include "adcdma_params.svh"

interface adcdma_if;
  logic                 req;
  logic [15:0]          data;
  adcdma_pkg::adcdma_addr_t indirect_address;
  logic                 peripheral_indirect_mode;
  logic                 ack;

  modport converter (output req, output data, output indirect_address,
                     output peripheral_indirect_mode, input ack);
  modport controller (input req, input data, input indirect_address,
                      input peripheral_indirect_mode, output ack);
endinterface : adcdma_if

// ===== hdl/adcdma_dma_ctrl.sv
/*
  far end: dma controller model in logic, ORs indirect address into its base
  and writes each result to ram through a plain write port.
  assumes software has loaded base and count before the converter is enabled.
*/
`timescale 1ns/1ps
`include "adcdma_params.svh"

module adcdma_dma_ctrl #(
  parameter int ADDR_W = 16
) (
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  adcdma_if.controller           link,
  input  wire logic [ADDR_W-1:0] DMA_DESTINATION_BASE,
  input  wire logic [15:0]       DMA_COUNT,
  input  wire logic              DMA_START,
  output logic                   RAM_WE,
  output logic [ADDR_W-1:0]      RAM_ADDR,
  output logic [15:0]            RAM_DATA,
  output logic                   DONE_IRQ,
  output logic                   BASE_CONFLICT
);
  if (ADDR_W < `ADCDMA_IA_W) begin : g_bad_addr_w
    $error("ADDR_W too small");
  end

  logic              armed_r, armed_nxt;
  logic [15:0]       left_r, left_nxt;
  logic              we_r, we_nxt, ack_r, ack_nxt, irq_r, irq_nxt, conf_r, conf_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [15:0]       data_r, data_nxt;
  logic [ADDR_W-1:0] ia_ext;

  assign ia_ext = {{(ADDR_W-`ADCDMA_IA_W){1'b0}}, link.indirect_address};

  always_comb begin
    armed_nxt = armed_r;
    left_nxt  = left_r;
    we_nxt    = 1'b0;
    ack_nxt   = 1'b0;
    irq_nxt   = 1'b0;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    conf_nxt  = conf_r;
    if (DMA_START) begin
      armed_nxt = (DMA_COUNT != 16'h0);
      left_nxt  = DMA_COUNT;
      conf_nxt  = 1'b0;
    end else if (armed_r && link.req && !ack_r) begin
      ack_nxt  = 1'b1;
      we_nxt   = 1'b1;
      data_nxt = link.data;
      // in peripheral indirect mode base bits under the address must be zero; flag a clash
      if (link.peripheral_indirect_mode && ((DMA_DESTINATION_BASE & ia_ext) != '0))
        conf_nxt = 1'b1;
      addr_nxt = DMA_DESTINATION_BASE | ia_ext;
      left_nxt = left_r - 16'h1;
      if (left_r == 16'h1) begin
        armed_nxt = 1'b0;
        irq_nxt   = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      armed_r <= 1'b0;
      left_r  <= 16'h0;
      we_r    <= 1'b0;
      ack_r   <= 1'b0;
      irq_r   <= 1'b0;
      conf_r  <= 1'b0;
      addr_r  <= '0;
      data_r  <= 16'h0;
    end else begin
      armed_r <= armed_nxt;
      left_r  <= left_nxt;
      we_r    <= we_nxt;
      ack_r   <= ack_nxt;
      irq_r   <= irq_nxt;
      conf_r  <= conf_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
    end
  end

  assign link.ack      = ack_r;
  assign RAM_WE        = we_r;
  assign RAM_ADDR      = addr_r;
  assign RAM_DATA      = data_r;
  assign DONE_IRQ      = irq_r;
  assign BASE_CONFLICT = conf_r;
endmodule : adcdma_dma_ctrl

// ===== hdl/adcdma_converter.sv
/*
  converter end: control bits, extended buffer fifo halves and the
  indirect address generator that feeds the dma controller.
  assumes results arrive as one-cycle strobes from the conversion core.
*/
`timescale 1ns/1ps
`include "adcdma_params.svh"

module adcdma_converter #(
  parameter int CHANNELS = 32
) (
  input  wire logic                     CLK,
  input  wire logic                     RESET_N,
  adcdma_if.converter                   link,
  input  wire logic [15:0]              CONVERTER_CONTROL_ONE,
  input  wire logic [15:0]              CONVERTER_CONTROL_TWO,
  input  wire logic [15:0]              CONVERTER_CONTROL_THREE,
  input  wire logic [15:0]              CONVERTER_CONTROL_FOUR,
  input  wire logic                     BUFFER_ORDER_SELECT,
  input  wire logic                     SPLIT_BUFFER_ENABLE,
  input  wire logic                     RESULT_VALID,
  input  wire logic [`ADCDMA_CH_W-1:0]  RESULT_CHANNEL,
  input  wire logic [15:0]              RESULT_DATA,
  output logic                          SAMPLING,
  output logic                          ACTIVE_HALF_STATUS,
  output logic                          CONVERTER_IRQ_FLAG,
  output logic                          RESULT_DROPPED
);
  if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
    $error("CHANNELS out of range");
  end

  logic                        conv_on, ext_dma_enable, dma_mode_select;
  adcdma_pkg::adcdma_len_t     channel_buffer_length;
  adcdma_pkg::adcdma_smpi_t    samples_per_interrupt;
  adcdma_pkg::adcdma_mode_e    mode;
  logic [7:0]                  chan_limit;

  assign conv_on               = CONVERTER_CONTROL_ONE[`ADCDMA_CON1_ON_BIT];
  assign ext_dma_enable        = CONVERTER_CONTROL_ONE[`ADCDMA_CON1_EXT_BIT];
  assign dma_mode_select       = CONVERTER_CONTROL_ONE[`ADCDMA_CON1_MODE_BIT];
  assign channel_buffer_length = CONVERTER_CONTROL_FOUR[`ADCDMA_CON4_LEN_HI:`ADCDMA_CON4_LEN_LO];
  assign samples_per_interrupt = CONVERTER_CONTROL_TWO[`ADCDMA_CON2_SMPI_HI:`ADCDMA_CON2_SMPI_LO];
  assign mode = dma_mode_select ? adcdma_pkg::ADCDMA_MODE_EXTBUF
                                : adcdma_pkg::ADCDMA_MODE_INDIRECT;
  // larger buffers leave fewer channel slots in eleven address bits
  assign chan_limit = (channel_buffer_length == `ADCDMA_LEN_128) ? 8'(`ADCDMA_CH_LIMIT_128) :
                      (channel_buffer_length == `ADCDMA_LEN_64)  ? 8'(`ADCDMA_CH_LIMIT_64)  :
                      8'(CHANNELS);

  // per-channel write positions, one word index each
  logic [6:0] pos_r   [CHANNELS];
  logic [6:0] pos_nxt [CHANNELS];
  logic [4:0] fill_r, fill_nxt;
  logic       half_r, half_nxt, irq_r, irq_nxt, drop_r, drop_nxt, sample_control_r, sample_control_nxt;
  logic       req_r, req_nxt;
  logic [15:0] data_r, data_nxt;
  adcdma_pkg::adcdma_addr_t ia_r, ia_nxt;
  adcdma_pkg::adcdma_xfer_e st_r, st_nxt;
  logic [6:0]  idx_mask, idx, pos_lim;
  logic [11:0] ia_wide;
  logic [4:0]  slot;
  logic        accept;

  // index wraps inside the chosen length: mask is size minus one
  assign idx_mask = 7'((8'h1 << channel_buffer_length) - 8'h1);
  assign pos_lim  = (7'(samples_per_interrupt) >= idx_mask) ? idx_mask : 7'(samples_per_interrupt);
  assign accept   = conv_on && ext_dma_enable && RESULT_VALID;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) pos_nxt[i] = pos_r[i];
    fill_nxt = fill_r;
    half_nxt = half_r;
    irq_nxt  = 1'b0;
    drop_nxt = 1'b0;
    sample_control_nxt = conv_on && CONVERTER_CONTROL_ONE[`ADCDMA_CON1_SAMPLE_CONTROL_BIT];
    req_nxt  = req_r;
    data_nxt = data_r;
    ia_nxt   = ia_r;
    st_nxt   = st_r;
    idx      = 7'h0;
    ia_wide  = 12'h0;
    slot     = 5'h0;
    case (st_r)
      adcdma_pkg::ADCDMA_IDLE: begin
        if (accept && (int'(RESULT_CHANNEL) >= CHANNELS ||
            {3'h0, RESULT_CHANNEL} >= chan_limit) && mode == adcdma_pkg::ADCDMA_MODE_INDIRECT) begin
          drop_nxt = 1'b1;
        end else if (accept) begin
          data_nxt = RESULT_DATA;
          req_nxt  = 1'b1;
          st_nxt   = adcdma_pkg::ADCDMA_REQ;
          if (mode == adcdma_pkg::ADCDMA_MODE_INDIRECT) begin
            // only the converted channel's slot is touched
            idx     = pos_r[RESULT_CHANNEL] & idx_mask;
            ia_wide = (12'(RESULT_CHANNEL) << (4'd1 + 4'(channel_buffer_length)))
                      | (12'(idx) << 1);
            ia_nxt  = ia_wide[`ADCDMA_IA_W-1:0];
            // wrap at whichever comes first: interrupt count or buffer end
            pos_nxt[RESULT_CHANNEL] = (pos_r[RESULT_CHANNEL] >= pos_lim) ? 7'h0
                                                                          : pos_r[RESULT_CHANNEL] + 7'h1;
          end else begin
            // buffer words and high channels both forwarded
            slot = BUFFER_ORDER_SELECT ? RESULT_CHANNEL : fill_r;
            if (SPLIT_BUFFER_ENABLE && !BUFFER_ORDER_SELECT && half_r)
              slot = 5'(fill_r + 5'(`ADCDMA_HALF_DEPTH));
            ia_nxt = adcdma_pkg::adcdma_addr_t'({slot, 1'b0});
            if (fill_r >= samples_per_interrupt ||
                (SPLIT_BUFFER_ENABLE && fill_r == 5'(`ADCDMA_HALF_DEPTH - 1))) begin
              fill_nxt = 5'h0;
              irq_nxt  = 1'b1;
              if (SPLIT_BUFFER_ENABLE) half_nxt = ~half_r;
            end else begin
              fill_nxt = fill_r + 5'h1;
            end
          end
        end else if (accept) begin
          drop_nxt = 1'b1;
        end
      end
      adcdma_pkg::ADCDMA_REQ: begin
        if (link.ack) begin
          req_nxt = 1'b0;
          st_nxt  = adcdma_pkg::ADCDMA_WAIT;
        end
        if (accept) drop_nxt = 1'b1;
      end
      adcdma_pkg::ADCDMA_WAIT: begin
        st_nxt = adcdma_pkg::ADCDMA_IDLE;
        if (accept) drop_nxt = 1'b1;
      end
      default: st_nxt = adcdma_pkg::ADCDMA_IDLE;
    endcase
    if (!conv_on || !ext_dma_enable) begin
      for (int i = 0; i < CHANNELS; i++) pos_nxt[i] = 7'h0;
      fill_nxt = 5'h0;
      half_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < CHANNELS; i++) pos_r[i] <= 7'h0;
      fill_r <= 5'h0;
      half_r <= 1'b0;
      irq_r  <= 1'b0;
      drop_r <= 1'b0;
      sample_control_r <= 1'b0;
      req_r  <= 1'b0;
      data_r <= 16'h0;
      ia_r   <= '0;
      st_r   <= adcdma_pkg::ADCDMA_IDLE;
    end else begin
      for (int i = 0; i < CHANNELS; i++) pos_r[i] <= pos_nxt[i];
      fill_r <= fill_nxt;
      half_r <= half_nxt;
      irq_r  <= irq_nxt;
      drop_r <= drop_nxt;
      sample_control_r <= sample_control_nxt;
      req_r  <= req_nxt;
      data_r <= data_nxt;
      ia_r   <= ia_nxt;
      st_r   <= st_nxt;
    end
  end

  assign link.req                      = req_r;
  assign link.data                     = data_r;
  assign link.indirect_address         = ia_r;
  assign link.peripheral_indirect_mode = ~dma_mode_select;
  assign SAMPLING           = sample_control_r;
  assign ACTIVE_HALF_STATUS = half_r;
  assign CONVERTER_IRQ_FLAG = irq_r;
  assign RESULT_DROPPED     = drop_r;
endmodule : adcdma_converter

// ===== testbench/adcdma_properties.sv
/*
  link checker: timing and address shape on the converter to controller link.
  assumes one clock and the async active-low reset of both ends.
*/
`timescale 1ns/1ps

module adcdma_properties (
  input wire logic                     CLK,
  input wire logic                     RESET_N,
  input wire logic                     req,
  input wire logic [15:0]              data,
  input wire adcdma_pkg::adcdma_addr_t indirect_address,
  input wire logic                     peripheral_indirect_mode,
  input wire logic                     ack
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_req_holds: assert property (req && !ack |=> req && $stable(data) && $stable(indirect_address))
    else $error("request changed before ack");
  a_ack_follows: assert property ($rose(req) |=> ack)
    else $error("ack missing one cycle after request");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_req_released: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_idle_gap: assert property ($fell(req) |=> !req)
    else $error("no idle cycle after transfer");
  a_ia_word_align: assert property (req |-> !indirect_address[0])
    else $error("indirect address not word aligned");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ext_slot_range: assert property (req && !peripheral_indirect_mode |-> indirect_address[10:6] == 5'h00)
    else $error("extended buffer slot out of range");
endmodule : adcdma_properties

// ===== testbench/adc_dma_indirect_address_gen_tb.sv
/*
  bench: both ends joined by the link interface, driven from the converter side.
  assumes a 50 MHz clock; the controller is armed with a large count.
*/
`timescale 1ns/1ps
`include "adcdma_params.svh"

module adc_dma_indirect_address_gen_tb;
  logic        CLK;
  logic        RESET_N;
  logic [15:0] con1, con2, con3, con4, base, rdat;
  logic        order, split, rv, start;
  logic [4:0]  rch;
  logic        we, drop, sample_control, half, irq, dirq, conflict;
  logic [15:0] waddr, wdata, cnt;
  logic        last_drop, last_irq, last_done;
  int          mismatches, tests_run, cycles;

  adcdma_if link();
  adcdma_converter adcdma_converter_i (.CLK(CLK), .RESET_N(RESET_N), .link(link),
    .CONVERTER_CONTROL_ONE(con1), .CONVERTER_CONTROL_TWO(con2), .CONVERTER_CONTROL_THREE(con3),
    .CONVERTER_CONTROL_FOUR(con4), .BUFFER_ORDER_SELECT(order), .SPLIT_BUFFER_ENABLE(split),
    .RESULT_VALID(rv), .RESULT_CHANNEL(rch), .RESULT_DATA(rdat), .SAMPLING(sample_control),
    .ACTIVE_HALF_STATUS(half), .CONVERTER_IRQ_FLAG(irq), .RESULT_DROPPED(drop));
  adcdma_dma_ctrl adcdma_dma_ctrl_i (.CLK(CLK), .RESET_N(RESET_N), .link(link),
    .DMA_DESTINATION_BASE(base), .DMA_COUNT(cnt), .DMA_START(start), .RAM_WE(we),
    .RAM_ADDR(waddr), .RAM_DATA(wdata), .DONE_IRQ(dirq), .BASE_CONFLICT(conflict));
  adcdma_properties adcdma_properties_i (.CLK(CLK), .RESET_N(RESET_N), .req(link.req),
    .data(link.data), .indirect_address(link.indirect_address),
    .peripheral_indirect_mode(link.peripheral_indirect_mode), .ack(link.ack));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  // off then on again, which also clears the per-channel positions
  task automatic cfg(input logic [15:0] c1, input logic [2:0] len, input logic [4:0] smpi);
    @(posedge CLK);
    con1  <= 16'h0000;
    start <= 1'b1;
    @(posedge CLK);
    start <= 1'b0;
    con1  <= c1;
    con4  <= {13'h0000, len};
    con2  <= {9'h000, smpi, 2'h0};
    @(posedge CLK);
  endtask : cfg

  task automatic send(input logic [4:0] ch, input logic [15:0] d, output logic ok);
    @(posedge CLK);
    rv   <= 1'b1;
    rch  <= ch;
    rdat <= d;
    @(posedge CLK);
    rv <= 1'b0;
    ok = 1'b0;
    // pulses launched at the take edge stand one cycle only
    #1;
    last_drop = drop;
    last_irq  = irq;
    repeat (8) begin
      #1;
      if (we === 1'b1 || drop === 1'b1) break;
      @(posedge CLK);
    end
    ok = we;
    last_done = dirq;
    repeat (2) @(posedge CLK);
  endtask : send

  task automatic t_lengths;
    logic ok;
    for (int len = 0; len < 8; len++) begin
      cfg(16'h8800, len[2:0], 5'h1f);
      send(5'h03, 16'h1230 + 16'(len), ok);
      chk("written", 1'b1, ok);
      chk("addr", base | (16'h0003 << (1 + len)), waddr);
      chk("data", 16'h1230 + 16'(len), wdata);
      chk("pia", 1'b1, link.peripheral_indirect_mode);
    end
    $display("done lengths");
  endtask : t_lengths

  task automatic t_increment;
    logic ok;
    cfg(16'h8800, 3'h2, 5'h1f);
    for (int i = 0; i < 5; i++) begin
      send(5'h05, 16'(i), ok);
      chk("pos addr", base | 16'h0028 | 16'((i % 4) << 1), waddr);
      send(5'h01, 16'(i), ok);
      chk("other ch", base | 16'h0008 | 16'((i % 4) << 1), waddr);
    end
    cfg(16'h8800, 3'h2, 5'h01);
    for (int i = 0; i < 3; i++) begin
      send(5'h05, 16'(i), ok);
      chk("smpi wrap", base | 16'h0028 | 16'((i % 2) << 1), waddr);
    end
    $display("done increment");
  endtask : t_increment

  task automatic t_refuse;
    logic ok;
    cfg(16'h8800, 3'h7, 5'h1f);
    send(5'h08, 16'h00aa, ok);
    chk("drop 128", 1'b1, last_drop);
    chk("no write", 1'b0, ok);
    cfg(16'h8800, 3'h6, 5'h1f);
    send(5'h10, 16'h00bb, ok);
    chk("drop 64", 1'b1, last_drop);
    send(5'h0f, 16'h00cc, ok);
    chk("last ch", base | 16'h0780, waddr);
    cfg(16'h8000, 3'h0, 5'h1f);
    send(5'h02, 16'h00dd, ok);
    chk("ext off", 1'b0, ok);
    $display("done refuse");
  endtask : t_refuse

  task automatic t_extbuf;
    logic ok;
    cfg(16'h9800, 3'h0, 5'h02);
    chk("pia off", 1'b0, link.peripheral_indirect_mode);
    send(5'h1c, 16'h0abc, ok);
    chk("ext slot0", base, waddr);
    send(5'h02, 16'h0def, ok);
    chk("ext slot1", base | 16'h0002, waddr);
    chk("ext data", 16'h0def, wdata);
    chk("irq early", 1'b0, last_irq);
    send(5'h03, 16'h0123, ok);
    chk("irq smpi", 1'b1, last_irq);
    send(5'h04, 16'h0456, ok);
    chk("fifo wrap", base, waddr);
    order <= 1'b1;
    cfg(16'h9800, 3'h0, 5'h1f);
    send(5'h1c, 16'h0789, ok);
    chk("aligned", base | 16'h0038, waddr);
    order <= 1'b0;
    split <= 1'b1;
    cfg(16'h9800, 3'h0, 5'h1f);
    chk("half first", 1'b0, half);
    for (int i = 0; i < 13; i++) send(5'h02, 16'(i), ok);
    chk("half flip", 1'b1, half);
    chk("split irq", 1'b1, last_irq);
    send(5'h02, 16'h0055, ok);
    chk("second half", base | 16'h001a, waddr);
    split <= 1'b0;
    $display("done extbuf");
  endtask : t_extbuf

  task automatic t_count;
    logic ok;
    cnt <= 16'h0002;
    cfg(16'h8800, 3'h0, 5'h1f);
    send(5'h01, 16'h0011, ok);
    chk("not done", 1'b0, last_done);
    send(5'h02, 16'h0022, ok);
    chk("done irq", 1'b1, last_done);
    chk("last write", 1'b1, ok);
    cnt <= 16'hffff;
    $display("done count");
  endtask : t_count

  task automatic t_conflict;
    logic ok;
    base <= 16'h0010;
    cfg(16'h8800, 3'h0, 5'h1f);
    send(5'h08, 16'h0001, ok);
    chk("conflict", 1'b1, conflict);
    base <= 16'h8000;
    cfg(16'h8800, 3'h0, 5'h1f);
    chk("cleared", 1'b0, conflict);
    $display("done conflict");
  endtask : t_conflict

  task automatic t_sample;
    @(posedge CLK);
    con1 <= 16'h8002;
    repeat (2) @(posedge CLK);
    #1;
    chk("sampling", 1'b1, sample_control);
    @(posedge CLK);
    con1 <= 16'h0002;
    repeat (2) @(posedge CLK);
    #1;
    chk("off", 1'b0, sample_control);
    $display("done sample");
  endtask : t_sample

  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // whole run is near 300 cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    {RESET_N, rv, start, order, split, rch} = '0;
    {con1, con2, con4, rdat} = '0;
    con3 = 16'h0003;
    base = 16'h8000;
    cnt  = 16'hffff;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    t_lengths();
    t_increment();
    t_refuse();
    t_extbuf();
    t_count();
    t_conflict();
    t_sample();
    close_out();
  end
endmodule : adc_dma_indirect_address_gen_tb
